// >>> common/sfw_pkg.sv
// Constants and types shared by the serial flash write control block
package sfw_pkg;

	// ******************************
	// Opcodes
	// ******************************
	localparam logic [7:0] OPC_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OPC_QUAD_PAGE_WRITE = 8'h32;
	localparam logic [7:0] OPC_FOUR_K_WIPE = 8'h20;
	localparam logic [7:0] OPC_HALF_BLOCK_CLEAR = 8'h52;
	localparam logic [7:0] OPC_BLOCK_CLEAR = 8'hd8;
	localparam logic [7:0] OPC_FULL_CLEAR_A = 8'hc7;
	localparam logic [7:0] OPC_FULL_CLEAR_B = 8'h60;
	localparam logic [7:0] OPC_RESET_ARM = 8'h66;
	localparam logic [7:0] OPC_RESET_GO = 8'h99;
	localparam logic [7:0] OPC_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OPC_WRITE_LOCK = 8'h04;
	localparam logic [7:0] OPC_VOL_UNLOCK = 8'h50;
	localparam logic [7:0] OPC_STATUS_FETCH = 8'h05;
	localparam logic [7:0] OPC_STATUS_STORE = 8'h01;

	// ******************************
	// Frame geometry in serial clocks
	// ******************************
	localparam logic [15:0] OPC_CLKS = 16'h0008;
	localparam logic [15:0] STORE_MIN_CLKS = 16'h0010;
	localparam logic [15:0] ADDR_END_CLKS = 16'h0020;
	localparam logic [15:0] PAGE_MIN_CLKS = 16'h0028;
	localparam logic [15:0] QUAD_MIN_CLKS = 16'h0022;
	localparam logic [15:0] CLK_COUNT_MAX = 16'hffff;

	// ******************************
	// Status byte layout and protection geometry
	// ******************************
	localparam int STAT_GUARD = 7;
	localparam int STAT_SMALL_LOCK = 6;
	localparam int STAT_LOW_END = 5;
	localparam int STAT_SIZE_HI = 4;
	localparam int STAT_SIZE_LO = 2;
	localparam logic [5:0] STAT_NV_DEFAULT = 6'h00;
	localparam logic [2:0] SIZE_NONE = 3'h0;
	localparam logic [2:0] SIZE_ALL = 3'h7;
	localparam int SECTOR_SHIFT = 12;
	localparam int BLOCK_SHIFT = 16;
	localparam logic [24:0] ARRAY_SPAN = 25'h1000000;

	// ******************************
	// Timing
	// ******************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int RECOVER_TIME_US = 28;
	localparam int RECOVER_CYCLES = (RECOVER_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int VOL_TIME_NS = 50;
	localparam int VOL_CYCLES = VOL_TIME_NS / CLK_PERIOD_NS;

	// ******************************
	// Types
	// ******************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_RECOVER = 3'b100
	} sfw_state_e;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_PAGE = 3'h1,
		OP_QUAD = 3'h2,
		OP_SECTOR = 3'h3,
		OP_HALF = 3'h4,
		OP_BLOCK = 3'h5,
		OP_FULL = 3'h6,
		OP_STATUS = 3'h7
	} sfw_op_e;

endpackage

// >>> hw/sfw_flash_ctrl.sv
// Serial flash command decode, write latch, status byte and protection control
`timescale 1ns/100ps
module sfw_flash_ctrl (
	// System clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Serial link pins
	input wire logic spi_clk_i,
	input wire logic cs_n_i,
	input wire logic [3:0] dq_i,
	input wire logic wp_n_i,
	output logic so_o,
	output logic so_oe_o,
	// Array core side
	input wire logic op_done_i,
	input wire logic cmp_i,
	input wire logic extra_lock_i,
	output logic op_start_o,
	output sfw_pkg::sfw_op_e op_kind_o,
	output logic [23:0] op_addr_o,
	output logic op_abort_o,
	output logic soft_reset_o,
	output logic [7:0] wr_data_o,
	output logic wr_data_vld_o,
	// Status view
	output logic [7:0] status_o
);
	import sfw_pkg::*;

	// ******************************
	// Functions
	// ******************************

	// Protected-range lookup on size, low end, small lock and complement
	function automatic logic is_protected(input logic [23:0] a, input logic [7:2] s,
			input logic cmp);
		logic [24:0] span;
		logic hit;
		span = 25'h0;
		hit = 1'b0;
		if (s[STAT_SIZE_HI:STAT_SIZE_LO] == SIZE_ALL) begin
			hit = 1'b1;
		end else if (s[STAT_SIZE_HI:STAT_SIZE_LO] != SIZE_NONE) begin
			span = (25'h1 << (s[STAT_SMALL_LOCK] ? SECTOR_SHIFT : BLOCK_SHIFT))
				<< (s[STAT_SIZE_HI:STAT_SIZE_LO] - 3'h1);
			if (s[STAT_LOW_END]) begin
				hit = ({1'b0, a} < span);
			end else begin
				hit = ({1'b0, a} >= (ARRAY_SPAN - span));
			end
		end
		is_protected = hit ^ cmp;
	endfunction

	// Any region protected at all
	function automatic logic any_protected(input logic [7:2] s, input logic cmp);
		if (cmp) begin
			any_protected = (s[STAT_SIZE_HI:STAT_SIZE_LO] != SIZE_ALL);
		end else begin
			any_protected = (s[STAT_SIZE_HI:STAT_SIZE_LO] != SIZE_NONE);
		end
	endfunction

	// ******************************
	// Link clock domain
	// ******************************
	logic link_rst;
	logic in_frame;
	logic [15:0] link_ck;
	logic [15:0] prev_ck;
	logic [15:0] next_ck;
	logic [7:0] link_sh;
	logic [7:0] next_sh;
	logic [7:0] link_opc;
	logic [23:0] link_addr;
	logic [7:0] link_byte;
	logic link_byte_tgl;
	logic link_frame_tgl;
	logic quad_phase;
	logic byte_done;
	logic [7:0] stat_pub;

	// Select high clears the per-frame state while the link clock stands
	assign link_rst = rst_i | cs_n_i;

	// Frame start marker
	always_ff @(posedge spi_clk_i or posedge link_rst) begin
		if (link_rst) begin
			in_frame <= 1'b0;
		end else begin
			in_frame <= 1'b1;
		end
	end

	always_comb begin
		prev_ck = in_frame ? link_ck : 16'h0;
		next_ck = (prev_ck == CLK_COUNT_MAX) ? prev_ck : prev_ck + 16'h1;
		quad_phase = (link_opc == OPC_QUAD_PAGE_WRITE) && (prev_ck >= ADDR_END_CLKS);
		next_sh = quad_phase ? {link_sh[3:0], dq_i} : {link_sh[6:0], dq_i[0]};
		// byte per 8 or 2 clocks
		byte_done = (next_ck > ADDR_END_CLKS)
			&& (quad_phase ? (next_ck[0] == 1'b0) : (next_ck[2:0] == 3'h0));
	end

	// Opcode, address and count capture; held stable after select rises
	always_ff @(posedge spi_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link_ck <= 16'h0;
			link_sh <= 8'h00;
			link_opc <= 8'h00;
			link_addr <= 24'h000000;
			link_frame_tgl <= 1'b0;
		end else begin
			link_ck <= next_ck;
			link_sh <= next_sh;
			if (!in_frame) begin
				link_frame_tgl <= ~link_frame_tgl;
			end
			if (next_ck == OPC_CLKS) begin
				link_opc <= next_sh;
			end
			if ((next_ck > OPC_CLKS) && (next_ck <= ADDR_END_CLKS)) begin
				link_addr <= {link_addr[22:0], dq_i[0]};
			end
		end
	end

	// page data bytes leave by toggle; each byte stands two or more link clocks
	always_ff @(posedge spi_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link_byte <= 8'h00;
			link_byte_tgl <= 1'b0;
		end else if (byte_done && ((link_opc == OPC_PAGE_WRITE)
				|| (link_opc == OPC_QUAD_PAGE_WRITE))) begin
			link_byte <= next_sh;
			link_byte_tgl <= ~link_byte_tgl;
		end
	end

	// status fetch, shifted out on falling edges, repeating
	always_ff @(negedge spi_clk_i or posedge link_rst) begin
		if (link_rst) begin
			so_o <= 1'b0;
			so_oe_o <= 1'b0;
		end else if ((link_opc == OPC_STATUS_FETCH) && (link_ck >= OPC_CLKS)) begin
			so_oe_o <= 1'b1;
			so_o <= stat_pub[~link_ck[2:0]];
		end
	end

	// ******************************
	// Crossings into the system clock
	// ******************************
	logic cs_s1;
	logic cs_s2;
	logic cs_s3;
	logic ft_s1;
	logic ft_s2;
	logic ft_seen;
	logic bt_s1;
	logic bt_s2;
	logic bt_s3;
	logic wp_s1;
	logic wp_s2;
	logic proc;

	// Two-stage synchronisers for select, frame toggle, byte toggle, protect pin
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			ft_s1 <= 1'b0;
			ft_s2 <= 1'b0;
			bt_s1 <= 1'b0;
			bt_s2 <= 1'b0;
			bt_s3 <= 1'b0;
			wp_s1 <= 1'b1;
			wp_s2 <= 1'b1;
		end else begin
			cs_s1 <= cs_n_i;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			ft_s1 <= link_frame_tgl;
			ft_s2 <= ft_s1;
			bt_s1 <= link_byte_tgl;
			bt_s2 <= bt_s1;
			bt_s3 <= bt_s2;
			wp_s1 <= wp_n_i;
			wp_s2 <= wp_s1;
		end
	end

	// frame acted on once after select rises, only if clocks arrived
	assign proc = cs_s2 && !cs_s3 && (ft_s2 != ft_seen);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ft_seen <= 1'b0;
		end else if (cs_s2 && !cs_s3) begin
			ft_seen <= ft_s2;
		end
	end

	// Page data bytes handed to the array core
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_data_o <= 8'h00;
			wr_data_vld_o <= 1'b0;
		end else begin
			wr_data_vld_o <= (bt_s2 != bt_s3);
			if (bt_s2 != bt_s3) begin
				wr_data_o <= link_byte;
			end
		end
	end

	// ******************************
	// Command decode
	// ******************************
	sfw_state_e state;
	logic [11:0] rec_cnt;
	logic write_latch;
	logic vol_en;
	logic arm;
	logic [7:2] nv_sr;
	logic [7:2] sr_v;
	logic idle;
	logic hwp;
	logic bare;
	logic write_ok;
	logic prot;
	logic [7:0] sr_byte;
	sfw_op_e next_kind;
	logic set_wel;
	logic clr_wel;
	logic vol_arm;
	logic vol_write;
	logic arm_set;
	logic reset_go;

	assign hwp = sr_v[STAT_GUARD] && !wp_s2;
	assign idle = (state == ST_IDLE);
	assign bare = (link_ck == OPC_CLKS);
	// latch gates all writes except the volatile status store; nothing starts while busy
	assign write_ok = idle && write_latch;
	assign prot = is_protected(link_addr, sr_v, cmp_i);

	// First byte after the status store opcode
	always_comb begin
		case (link_ck)
			16'h0010: sr_byte = link_addr[7:0];
			16'h0018: sr_byte = link_addr[15:8];
			default: sr_byte = link_addr[23:16];
		endcase
	end

	always_comb begin
		next_kind = OP_NONE;
		set_wel = 1'b0;
		clr_wel = 1'b0;
		vol_arm = 1'b0;
		vol_write = 1'b0;
		arm_set = 1'b0;
		reset_go = 1'b0;
		if (proc) begin
			case (link_opc)
				OPC_WRITE_UNLOCK: set_wel = idle && bare;
				OPC_WRITE_LOCK: clr_wel = idle && bare;
				OPC_VOL_UNLOCK: vol_arm = idle && bare;
				OPC_RESET_ARM: arm_set = bare;
				OPC_RESET_GO: reset_go = bare && arm;
				OPC_STATUS_STORE: begin
					if (idle && !hwp && (link_ck >= STORE_MIN_CLKS)
							&& (link_ck <= ADDR_END_CLKS) && (link_ck[2:0] == 3'h0)) begin
						if (vol_en) begin
							vol_write = 1'b1;
						end else if (write_latch) begin
							next_kind = OP_STATUS;
						end
					end
				end
				OPC_PAGE_WRITE: begin
					if (write_ok && !prot && (link_ck >= PAGE_MIN_CLKS)
							&& (link_ck[2:0] == 3'h0)) begin
						next_kind = OP_PAGE;
					end
				end
				OPC_QUAD_PAGE_WRITE: begin
					if (write_ok && !prot && (link_ck >= QUAD_MIN_CLKS)
							&& (link_ck[0] == 1'b0)) begin
						next_kind = OP_QUAD;
					end
				end
				OPC_FOUR_K_WIPE, OPC_HALF_BLOCK_CLEAR, OPC_BLOCK_CLEAR: begin
					if (write_ok && !prot && (link_ck == ADDR_END_CLKS)) begin
						if (link_opc == OPC_FOUR_K_WIPE) begin
							next_kind = OP_SECTOR;
						end else if (link_opc == OPC_HALF_BLOCK_CLEAR) begin
							next_kind = OP_HALF;
						end else begin
							next_kind = OP_BLOCK;
						end
					end
				end
				OPC_FULL_CLEAR_A, OPC_FULL_CLEAR_B: begin
					// full erase only when nothing protected
					if (write_ok && bare && !any_protected(sr_v, cmp_i) && !extra_lock_i) begin
						next_kind = OP_FULL;
					end
				end
				default: ;
			endcase
		end
	end

	// ******************************
	// Operation sequencer
	// ******************************
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			rec_cnt <= 12'h000;
			op_start_o <= 1'b0;
			op_kind_o <= OP_NONE;
			op_addr_o <= 24'h000000;
			op_abort_o <= 1'b0;
			soft_reset_o <= 1'b0;
		end else begin
			op_start_o <= 1'b0;
			op_abort_o <= 1'b0;
			soft_reset_o <= reset_go;
			if (reset_go) begin
				// reset aborts a running cycle; erase waits out recovery
				op_abort_o <= (state == ST_BUSY);
				rec_cnt <= 12'(RECOVER_CYCLES - 1);
				if ((state == ST_RECOVER) || ((state == ST_BUSY) && (op_kind_o >= OP_SECTOR)
						&& (op_kind_o <= OP_FULL))) begin
					state <= ST_RECOVER;
				end else begin
					state <= ST_IDLE;
				end
			end else begin
				unique case (state)
					ST_IDLE: begin
						if (next_kind != OP_NONE) begin
							state <= ST_BUSY;
							op_start_o <= 1'b1;
							op_kind_o <= next_kind;
							op_addr_o <= link_addr;
						end
					end
					// running cycle ends on its own completion or on a software reset
					ST_BUSY: begin
						if (op_done_i) begin
							state <= ST_IDLE;
						end
					end
					ST_RECOVER: begin
						if (rec_cnt == 12'h000) begin
							state <= ST_IDLE;
						end else begin
							rec_cnt <= rec_cnt - 12'h001;
						end
					end
				endcase
			end
		end
	end

	// latch, cleared at power-up and on completion
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			write_latch <= 1'b0;
		end else if (reset_go || ((state == ST_BUSY) && op_done_i)) begin
			write_latch <= 1'b0;
		end else if (set_wel) begin
			write_latch <= 1'b1;
		end else if (clr_wel) begin
			write_latch <= 1'b0;
		end
	end

	// arms last only until the next frame
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			vol_en <= 1'b0;
			arm <= 1'b0;
		end else if (proc) begin
			vol_en <= vol_arm;
			arm <= arm_set;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			nv_sr <= STAT_NV_DEFAULT;
			sr_v <= STAT_NV_DEFAULT;
		end else if (reset_go) begin
			sr_v <= nv_sr;
		end else if (vol_write) begin
			sr_v <= sr_byte[7:2];
		end else if (idle && (next_kind == OP_STATUS)) begin
			nv_sr <= sr_byte[7:2];
			sr_v <= sr_byte[7:2];
		end
	end

	// status byte; link copy only moves while select is high
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_o <= 8'h00;
			stat_pub <= 8'h00;
		end else begin
			status_o <= {sr_v, write_latch, !idle};
			if (cs_s2) begin
				stat_pub <= {sr_v, write_latch, !idle};
			end
		end
	end

	// ******************************
	// Assertions
	// ******************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_cmd(logic [7:0] code);
		proc && (link_opc == code);
	endsequence
	sequence s_reset_busy;
		s_cmd(OPC_RESET_GO) ##0 arm && (state == ST_BUSY);
	endsequence

	AST_WEL_SET: assert property (s_cmd(OPC_WRITE_UNLOCK) ##0 bare && idle |=> write_latch)
		else $error("write unlock did not set the latch");
	AST_WEL_CLR: assert property (s_cmd(OPC_WRITE_LOCK) ##0 bare && idle |=> !write_latch)
		else $error("write lock did not clear the latch");
	AST_START_NEEDS_WEL: assert property (op_start_o |-> $past(write_latch))
		else $error("operation started with latch clear");
	AST_VOL_FAST: assert property (vol_write |=> ##[0:4] (sr_v == $past(sr_byte[7:2])))
		else $error("volatile status not applied in time");
	AST_DONE_CLR: assert property ((state == ST_BUSY) && op_done_i && !reset_go |=> !write_latch && idle)
		else $error("completion did not clear latch and busy");
	AST_ARM_CANCEL: assert property (proc && arm && !arm_set && (link_opc != OPC_RESET_GO) |=> !arm ##1 !soft_reset_o)
		else $error("reset arm survived another command");
	AST_HWP_REJECT: assert property (s_cmd(OPC_STATUS_STORE) ##0 hwp |=> $stable(sr_v) && !op_start_o)
		else $error("status store accepted under guard");
	AST_BUSY_IGNORE: assert property ((state == ST_BUSY) && proc |=> !op_start_o)
		else $error("command started while busy");
	AST_RESET_ABORT: assert property (s_reset_busy |=> op_abort_o && soft_reset_o && !write_latch)
		else $error("software reset did not abort the cycle");
	AST_RESET_RESTORE: assert property (reset_go |=> (sr_v == $past(nv_sr)))
		else $error("reset did not restore stored status");
	AST_ERASE_LEN: assert property (s_cmd(OPC_FOUR_K_WIPE) ##0 (link_ck != ADDR_END_CLKS) |=> !op_start_o)
		else $error("erase with wrong address length started");
	AST_FULL_PROT: assert property (proc && (next_kind == OP_FULL) |-> !any_protected(sr_v, cmp_i))
		else $error("full erase with protected region");

endmodule

// >>> verification/sfw_host_model.sv
// Host serial controller model that frames commands onto the link
`timescale 1ns/100ps
module sfw_host_model (
	// Link pins driven by the host
	output logic spi_clk_o,
	output logic cs_n_o,
	output logic [3:0] dq_o,
	// Status line from the device
	input wire logic so_i,
	// Last eight bits seen on the status line
	output logic [7:0] rx_o
);
	// Idle levels: clock parked low, select high
	initial begin
		spi_clk_o = 1'b0;
		cs_n_o = 1'b1;
		dq_o = 4'h5;
		rx_o = 8'h00;
	end

	// msb first shifting
	// Clock stands still outside frames; 125 ns period inside
	task automatic frame(input logic [63:0] v, input int n, input bit quad);
		int p;
		p = 63;
		#3.3 cs_n_o <= 1'b0;
		for (int i = 0; i < n; i++) begin
			#20;
			if (quad && i >= 32) begin
				dq_o <= v[p -: 4];
				p = p - 4;
			end else begin
				dq_o <= {~dq_o[3:1], v[p]};
				p = p - 1;
			end
			#42.5 spi_clk_o <= 1'b1;
			rx_o <= {rx_o[6:0], so_i};
			#62.5 spi_clk_o <= 1'b0;
		end
		#20 cs_n_o <= 1'b1;
		// Released lines must not keep the last value
		dq_o <= ~dq_o;
	endtask
endmodule

// >>> verification/tb_sfw_flash_ctrl.sv
// Self-checking bench for the serial flash write control block
`timescale 1ns/100ps
module tb_sfw_flash_ctrl;
	import sfw_pkg::*;
	logic sys_clk_i, rst_i, spi_clk, cs_n, wp_n, op_done, cmp, extra_lock;
	logic so, so_oe, op_start, op_abort, soft_rst, wr_vld;
	logic [3:0] dq;
	logic [23:0] op_addr;
	logic [7:0] wr_data, status, rx, last_wr;
	sfw_op_e op_kind;
	int fail_count, comparisons, n_start, n_abort, n_soft, n_oe;
	logic [7:0] erase_ops [3] = '{OPC_FOUR_K_WIPE, OPC_HALF_BLOCK_CLEAR, OPC_BLOCK_CLEAR};
	sfw_op_e erase_kinds [3] = '{OP_SECTOR, OP_HALF, OP_BLOCK};
	logic [7:0] full_ops [2] = '{OPC_FULL_CLEAR_A, OPC_FULL_CLEAR_B};

	// ******************************
	// Clock, instances and pulse counters
	// ******************************
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	sfw_host_model host (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .dq_o(dq), .so_i(so), .rx_o(rx));

	sfw_flash_ctrl dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_clk_i(spi_clk),
		.cs_n_i(cs_n), .dq_i(dq), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe),
		.op_done_i(op_done), .cmp_i(cmp), .extra_lock_i(extra_lock),
		.op_start_o(op_start), .op_kind_o(op_kind), .op_addr_o(op_addr),
		.op_abort_o(op_abort), .soft_reset_o(soft_rst), .wr_data_o(wr_data),
		.wr_data_vld_o(wr_vld), .status_o(status));

	// Count one-cycle pulses and cycles of status output enable from the design
	always @(posedge sys_clk_i) begin
		if (op_start === 1'b1) n_start++;
		if (op_abort === 1'b1) n_abort++;
		if (soft_rst === 1'b1) n_soft++;
		if (so_oe === 1'b1) n_oe++;
		if (wr_vld === 1'b1) last_wr = wr_data;
	end

	// ******************************
	// Shared tasks
	// ******************************
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	// One frame, then a select-high gap long enough for decode
	task automatic send(input logic [63:0] v, input int n, input bit quad);
		host.frame(v, n, quad);
		cyc(10);
	endtask

	task automatic cmd(input logic [7:0] op);
		send({op, 56'h0}, 8, 1'b0);
	endtask

	// Status fetch frame; the second byte lands in rx
	task automatic fetch();
		send({OPC_STATUS_FETCH, 56'h0}, 16, 1'b0);
	endtask

	task automatic done();
		@(posedge sys_clk_i) op_done <= 1'b1;
		@(posedge sys_clk_i) op_done <= 1'b0;
		cyc(3);
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ******************************
	// Scenarios
	// ******************************
	task automatic t_latch();
		int o;
		chk(status, 8'h00);
		chk(op_kind, OP_NONE);
		cmd(OPC_WRITE_UNLOCK);
		chk(status, 8'h02);
		o = n_oe;
		fetch();
		chk(rx, 8'h02);
		chk(n_oe > o, 1'b1);
		o = n_oe;
		cmd(OPC_WRITE_LOCK);
		chk(status, 8'h00);
		chk(n_oe, o);
	endtask

	task automatic t_page();
		int s;
		s = n_start;
		send({OPC_PAGE_WRITE, 24'h123456, 8'ha5, 24'h0}, 40, 1'b0);
		chk(n_start, s);
		cmd(OPC_WRITE_UNLOCK);
		send({OPC_PAGE_WRITE, 24'h123456, 8'h5a, 24'h0}, 40, 1'b0);
		chk(n_start, s + 1);
		chk(op_kind, OP_PAGE);
		chk(op_addr, 24'h123456);
		chk(last_wr, 8'h5a);
		chk(status, 8'h03);
		fetch();
		chk(rx, 8'h03);
		send({OPC_FOUR_K_WIPE, 24'h000000, 32'h0}, 32, 1'b0);
		chk(n_start, s + 1);
		done();
		chk(status, 8'h00);
		cmd(OPC_WRITE_UNLOCK);
		send({OPC_QUAD_PAGE_WRITE, 24'h00abc0, 8'h3c, 24'h0}, 34, 1'b1);
		chk(op_kind, OP_QUAD);
		chk(op_addr, 24'h00abc0);
		chk(last_wr, 8'h3c);
		done();
		chk(status, 8'h00);
	endtask

	task automatic t_erase();
		int s;
		for (int i = 0; i < 3; i++) begin
			cmd(OPC_WRITE_UNLOCK);
			s = n_start;
			send({erase_ops[i], 24'h010000, 32'h0}, 31, 1'b0);
			chk(n_start, s);
			send({erase_ops[i], 24'h010000, 32'h0}, 32, 1'b0);
			chk(n_start, s + 1);
			chk(op_kind, erase_kinds[i]);
			chk(op_addr, 24'h010000);
			done();
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk_i) extra_lock <= 1'b1;
			cmd(OPC_WRITE_UNLOCK);
			s = n_start;
			cmd(full_ops[i]);
			chk(n_start, s);
			@(posedge sys_clk_i) extra_lock <= 1'b0;
			cmd(full_ops[i]);
			chk(n_start, s + 1);
			chk(op_kind, OP_FULL);
			done();
			chk(status, 8'h00);
		end
		// Complement set with size zero protects the whole array
		@(posedge sys_clk_i) cmp <= 1'b1;
		cmd(OPC_WRITE_UNLOCK);
		s = n_start;
		cmd(OPC_FULL_CLEAR_A);
		chk(n_start, s);
		send({OPC_FOUR_K_WIPE, 24'h010000, 32'h0}, 32, 1'b0);
		chk(n_start, s);
		@(posedge sys_clk_i) cmp <= 1'b0;
		cmd(OPC_WRITE_LOCK);
		chk(status, 8'h00);
	endtask

	task automatic t_volatile_reset();
		int r;
		cmd(OPC_VOL_UNLOCK);
		chk(status, 8'h00);
		send({OPC_STATUS_STORE, 8'h1c, 48'h0}, 16, 1'b0);
		chk(status, 8'h1c);
		r = n_soft;
		cmd(OPC_RESET_ARM);
		cmd(OPC_WRITE_UNLOCK);
		cmd(OPC_RESET_GO);
		chk(n_soft, r);
		chk(status, 8'h1e);
		cmd(OPC_RESET_ARM);
		cmd(OPC_RESET_GO);
		chk(n_soft, r + 1);
		chk(status, 8'h00);
	endtask

	task automatic t_abort();
		int a;
		a = n_abort;
		cmd(OPC_WRITE_UNLOCK);
		send({OPC_FOUR_K_WIPE, 24'h002000, 32'h0}, 32, 1'b0);
		cmd(OPC_RESET_ARM);
		cmd(OPC_RESET_GO);
		chk(n_abort, a + 1);
		chk(status, 8'h01);
		cyc(RECOVER_CYCLES - 100);
		chk(status[0], 1'b1);
		// wait out recovery before next command
		cyc(200);
		chk(status, 8'h00);
	endtask

	task automatic t_protect();
		int s;
		cmd(OPC_WRITE_UNLOCK);
		send({OPC_STATUS_STORE, 8'h9c, 48'h0}, 16, 1'b0);
		chk(status, 8'h9f);
		done();
		chk(status, 8'h9c);
		cmd(OPC_WRITE_UNLOCK);
		s = n_start;
		send({OPC_PAGE_WRITE, 24'hfff000, 8'h11, 24'h0}, 40, 1'b0);
		chk(n_start, s);
		@(posedge sys_clk_i) wp_n <= 1'b0;
		cyc(5);
		send({OPC_STATUS_STORE, 8'h00, 48'h0}, 16, 1'b0);
		chk(n_start, s);
		chk(status[7:2], 6'h27);
		@(posedge sys_clk_i) wp_n <= 1'b1;
		@(posedge sys_clk_i) rst_i <= 1'b1;
		cyc(2);
		rst_i <= 1'b0;
		cyc(3);
		chk(status, 8'h00);
		// Bottom-end 4 KB protection through a volatile store
		cmd(OPC_VOL_UNLOCK);
		send({OPC_STATUS_STORE, 8'h64, 48'h0}, 16, 1'b0);
		chk(status, 8'h64);
		cmd(OPC_WRITE_UNLOCK);
		s = n_start;
		send({OPC_PAGE_WRITE, 24'h000800, 8'h22, 24'h0}, 40, 1'b0);
		chk(n_start, s);
		send({OPC_PAGE_WRITE, 24'h001000, 8'h22, 24'h0}, 40, 1'b0);
		chk(n_start, s + 1);
		chk(op_addr, 24'h001000);
		done();
	endtask

	// Watchdog sized well beyond the expected run
	initial begin
		#600us;
		fail_count++;
		wrap_up();
	end

	// Main sequence
	initial begin
		rst_i = 1'b1;
		wp_n = 1'b1;
		op_done = 1'b0;
		cmp = 1'b0;
		extra_lock = 1'b0;
		fail_count = 0;
		comparisons = 0;
		n_start = 0;
		n_abort = 0;
		n_soft = 0;
		n_oe = 0;
		last_wr = 8'h00;
		cyc(4);
		rst_i <= 1'b0;
		cyc(3);
		t_latch();
		t_page();
		t_erase();
		t_volatile_reset();
		t_abort();
		t_protect();
		wrap_up();
	end
endmodule
